// [bench/esp_core_model.sv]
// core-side model issuing stack and register requests
`timescale 1ns/10ps
module esp_core_model (
   input wire logic clk,
   output logic sfr_wr = 1'b0,
   output logic sfr_rd = 1'b0,
   output logic [7:0] sfr_addr = 8'h00,
   output logic [7:0] sfr_wdata = 8'h00,
   output logic push_req = 1'b0,
   output logic [7:0] push_data = 8'h00,
   output logic pop_req = 1'b0,
   output logic pc_push_req = 1'b0,
   output logic pc_pop_req = 1'b0,
   output logic [15:0] pc_in = 16'h0000
);
   // one request per call: raised after an edge, dropped after the taking edge
   // pointer writes come only from main flow, never from a service routine
   task automatic op(input logic [3:0] k, input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= v[7:0];
      push_data <= v[7:0];
      pc_in <= v;
      {push_req, pop_req, pc_push_req, pc_pop_req, sfr_wr, sfr_rd} <=
         {k == 4'h1, k == 4'h2, k == 4'h3, k == 4'h4, k == 4'h5, k == 4'h6};
      @(posedge clk);
      {push_req, pop_req, pc_push_req, pc_pop_req, sfr_wr, sfr_rd} <= 6'h00;
      // pc transfers hold busy two more cycles, requests then would be lost
      if (k == 4'h3 || k == 4'h4) begin
         repeat (2) @(posedge clk);
      end
   endtask
endmodule

// [bench/esp_guard_sva.sv]
// port-level assertions for the stack pointer guard
`timescale 1ns/10ps
module esp_guard_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic push_req,
   input wire logic pop_req,
   input wire logic pc_push_req,
   input wire logic pc_pop_req,
   input wire logic pop_valid,
   input wire logic pc_valid,
   input wire logic busy,
   input wire logic viol_irq_req,
   input wire logic viol_rst_req
);
   logic [7:1] ctl_r;
   // mirror of guard control bits 7..1 from accepted writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl_r <= 7'h00;
      end else if (sfr_wr && !busy && sfr_addr == 8'hbf) begin
         ctl_r <= sfr_wdata[7:1];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_pop_answer: assert property (pop_req && !busy && !push_req && !pc_push_req |=> pop_valid)
      else $error("pop gave no data pulse");
   chk_pc_walk: assert property (pc_pop_req && !busy && !push_req && !pc_push_req && !pop_req
      |=> busy ##1 (busy && pc_valid) ##1 !busy) else $error("pc restore walk wrong");
   chk_pc_push_busy: assert property (pc_push_req && !busy && !push_req |=> busy [*2] ##1 !busy)
      else $error("pc save busy window wrong");
   // the mirror one cycle back is the setting the violating update saw
   chk_irq_cause: assert property (viol_irq_req |-> $past(ctl_r[1]) && !$past(ctl_r[2]))
      else $error("irq pulse without enabled irq response");
   chk_rst_cause: assert property (viol_rst_req |-> $past(ctl_r[1]) && $past(ctl_r[2]))
      else $error("reset pulse without enabled reset response");
   chk_one_resp: assert property (!(viol_irq_req && viol_rst_req))
      else $error("irq and reset requested together");
   chk_unmapped_read: assert property (sfr_rd && !busy && !(sfr_addr inside {8'h81, 8'hb7, 8'hbf})
      |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   chk_rsvd_bit: assert property (sfr_rd && !busy && sfr_addr == 8'hb7 |=> sfr_rdata[7])
      else $error("pointer high bit 7 read low");
   chk_guard_read: assert property (sfr_rd && !busy && sfr_addr == 8'hbf
      |=> sfr_rdata[7:1] == $past(ctl_r)) else $error("guard control readback wrong");
endmodule
bind esp_guard esp_guard_sva u_esp_guard_sva (.clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .push_req(push_req), .pop_req(pop_req),
   .pc_push_req(pc_push_req), .pc_pop_req(pc_pop_req), .pop_valid(pop_valid), .pc_valid(pc_valid),
   .busy(busy), .viol_irq_req(viol_irq_req), .viol_rst_req(viol_rst_req));

// [bench/tb.sv]
// self-checking bench for the stack pointer guard
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin_rst_n = 1'b0;
   wire logic sfr_wr, sfr_rd, push_req, pop_req, pc_push_req, pc_pop_req;
   wire logic pop_valid, pc_valid, busy, viol_irq_req, viol_rst_req;
   wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, push_data, pop_data;
   wire logic [15:0] pc_in, pc_out;
   int bad_count = 0;
   int checks = 0;
   int irq_n = 0;
   int rst_pulses = 0;
   int cyc = 0;
   logic [15:0] got;
   logic [27:0] r;
   // op code, address, data or expected value; base never set below 0x100
   logic [27:0] rows [$] = {28'h6810000, 28'h6550000, 28'h100003c, 28'h6810001, 28'h10000a5, 28'h20000a5,
      28'h200003c, 28'h6810000, 28'h3001234, 28'h2000012, 28'h2000034, 28'h300beef, 28'h400beef,
      28'h58100ff, 28'h5b700b7, 28'h1000011, 28'h6b700b6, 28'h6810000, 28'h2000011, 28'h6b700b5,
      28'h5bf00f8, 28'h5b700b7, 28'h6bf00f8, 28'h5b700b6, 28'h5bf0002, 28'h5b700b5, 28'h6b700f6,
      28'h68100ff, 28'h5b700b6, 28'h6b700b6, 28'h5bf000a, 28'h5b700b7, 28'h6bf000b, 28'h5bf000a,
      28'h6bf000b, 28'h5b700b6, 28'h5bf000a, 28'h6bf000a, 28'h5bf0002, 28'h5b700b7, 28'h6bf0002,
      28'h5b700b6, 28'h5bf000e, 28'h5b700b7, 28'h6bf000f};
   esp_guard u_esp_guard (.clk(clk), .rst_n(rst_n), .pin_rst_n(pin_rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .push_req(push_req),
      .push_data(push_data), .pop_req(pop_req), .pc_push_req(pc_push_req), .pc_pop_req(pc_pop_req),
      .pc_in(pc_in), .pop_data(pop_data), .pop_valid(pop_valid), .pc_out(pc_out), .pc_valid(pc_valid),
      .busy(busy), .viol_irq_req(viol_irq_req), .viol_rst_req(viol_rst_req));
   esp_core_model u_esp_core_model (.clk(clk), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .push_req(push_req), .push_data(push_data), .pop_req(pop_req),
      .pc_push_req(pc_push_req), .pc_pop_req(pc_pop_req), .pc_in(pc_in));
   // clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   // event pulse counts and hang guard
   always @(posedge clk) begin
      cyc++;
      if (viol_irq_req === 1'b1) irq_n++;
      if (viol_rst_req === 1'b1) rst_pulses++;
      if (cyc == 2000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // reset, then read the guard control; pin reset also clears the flags
   task automatic rst_rd(input logic pin, input logic [7:0] e);
      @(posedge clk);
      rst_n <= 1'b0;
      pin_rst_n <= ~pin;
      @(posedge clk);
      rst_n <= 1'b1;
      pin_rst_n <= 1'b1;
      u_esp_core_model.op(4'h6, 8'hbf, 16'h0000);
      #1;
      `CHK("guard control", e, sfr_rdata)
      u_esp_core_model.op(4'h6, 8'hb7, 16'h0000);
      #1;
      `CHK("pointer high", 8'h89, sfr_rdata)
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      pin_rst_n <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         u_esp_core_model.op(r[27:24], r[23:16], r[15:0]);
         #1;
         got = r[27:24] == 4'h4 ? pc_out : {8'h00, r[27:24] == 4'h2 ? pop_data : sfr_rdata};
         if (!r[24]) `CHK("row", r[15:0], got)
      end
      `CHK("irq pulses", 2, irq_n)
      `CHK("reset pulses", 1, rst_pulses)
      // flag set by the reset response must survive a block reset
      rst_rd(1'b0, 8'h01);
      rst_rd(1'b1, 8'h00);
      end_sim();
   end
endmodule

// [design/esp_guard.sv]
// extended stack pointer with floor and waterline guard
// Summary of operation
// - push increments the pointer first, then writes the byte there.
// - pop reads the byte at the pointer, then decrements the pointer.
// - stack address is low register bits plus three low high-register bits.
// - after reset the stack base is 0x100.
// - high register bits 5..3 give the three top base address bits.
// - push past top of ram wraps the pointer to the base.
// - guard off after reset; enable bit arms waterline and floor checks.
// - waterline sits at 0x7ff minus the five-bit level field.
// - level zero means no waterline detection and no event.
// - guarded write setting pointer below base is flagged and discarded.
// - response bit set: violation resets immediately.
// - response bit clear: violation requests the watchdog interrupt vector.
// - violation event ignores the global interrupt enable bit.
// - guard disabled: no violation interrupts and no violation resets.
// - waterline flag set on excess; software clear works only below waterline.
// - boundary or watchdog reset keeps waterline flag; pin reset clears it.
// - floor flag set on violation; software or pin reset clears it.
// - one write raising base above the written pointer raises floor violation.
// - calls and interrupts push the program counter; returns pop it.
`timescale 1ns/10ps
`include "esp_defs.svh"
module esp_guard (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_rst_n,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic push_req,
   input wire logic [7:0] push_data,
   input wire logic pop_req,
   input wire logic pc_push_req,
   input wire logic pc_pop_req,
   input wire logic [15:0] pc_in,
   output logic [7:0] pop_data,
   output logic pop_valid,
   output logic [15:0] pc_out,
   output logic pc_valid,
   output logic busy,
   output logic viol_irq_req,
   output logic viol_rst_req
);
   // interface notes for whoever wires this to the core:
   // - every request is a one-cycle strobe, taken only while busy is low
   // - stack ops win over pointer writes in the same cycle; the pointer
   //   part of such a write is lost, other register writes still land
   // - pc saves and restores take three cycles; the core must wait for
   //   busy to fall, requests seen while busy are simply dropped
   // - read data is registered and appears the cycle after the strobe
   // - violation requests are one-cycle pulses, one cycle after the
   //   pointer update that caused them
   // - only register writes are floor-checked; a pop may go below base,
   //   trading full coverage for a cheaper compare path
   // - the waterline is judged only when the pointer is really stored,
   //   so a pointer parked above it raises one event, not one per cycle
   // the stack lives in this ram; the core writes nothing else here
   logic [7:0] ram [0:`ESP_RAM_WORDS-1];
   logic [7:0] spl_r, spl_nxt, sph_r, sph_nxt, grd_r, grd_nxt;
   logic [7:0] pop_data_r, pop_data_nxt, sfr_rdata_r, sfr_rdata_nxt;
   logic [7:0] pch_r, pch_nxt;
   logic [15:0] pc_out_r, pc_out_nxt;
   logic pop_valid_r, pop_valid_nxt, pc_valid_r, pc_valid_nxt;
   logic irq_r, irq_nxt, rst_r, rst_nxt, is_push_r, is_push_nxt;
   logic wr_en;
   esp_pkg::esp_addr_t wr_addr;
   logic [7:0] wr_byte;
   esp_pkg::esp_state_t st_r, st_nxt;

   // helpers shared by the push, pc save and pointer write paths;
   // keeping them in functions means the wrap and base rules live in one
   // place and cannot drift apart between the single and two-byte paths

   // base address from the three base bits, low eight bits zero
   function automatic esp_pkg::esp_addr_t base_of(input logic [7:0] stack_ptr_high);
      base_of = {stack_ptr_high[`ESP_SPH_BASE_HI:`ESP_SPH_BASE_LO], 8'h00};
   endfunction

   // pointer after a push, wrapping from the top back to base
   function automatic esp_pkg::esp_addr_t inc_ptr(input esp_pkg::esp_addr_t p, input esp_pkg::esp_addr_t b);
      inc_ptr = (p == `ESP_RAM_TOP) ? b : esp_pkg::esp_addr_t'(p + 11'h001);
   endfunction

   // decoded views of the registers, used by the sequencer below;
   // the waterline subtract is only eleven bits so it stays cheap
   esp_pkg::esp_addr_t sp_w, base_w, wline_w;
   logic guard_on, wl_live;
   assign sp_w = {sph_r[`ESP_SPH_PTR_HI:0], spl_r};
   assign base_w = base_of(sph_r);
   assign guard_on = grd_r[`ESP_GRD_EN_BIT];
   assign wline_w = `ESP_RAM_TOP - {6'h00, grd_r[`ESP_GRD_LVL_HI:`ESP_GRD_LVL_LO]};
   assign wl_live = guard_on && (grd_r[`ESP_GRD_LVL_HI:`ESP_GRD_LVL_LO] != 5'h00);

   // sequencing of two-byte pc moves and single byte stack ops
   // np is the candidate pointer, nb the base it is judged against;
   // upd marks the cycles in which a new pointer is really stored
   always_comb begin
      esp_pkg::esp_addr_t np, nb;
      logic floor_v, wl_v, upd;
      logic [7:0] hv;
      np = sp_w;
      nb = base_w;
      floor_v = 1'b0;
      wl_v = 1'b0;
      upd = 1'b0;
      hv = sph_r;
      spl_nxt = spl_r;
      sph_nxt = sph_r;
      grd_nxt = grd_r;
      st_nxt = st_r;
      pch_nxt = pch_r;
      is_push_nxt = is_push_r;
      pop_data_nxt = pop_data_r;
      pop_valid_nxt = 1'b0;
      pc_out_nxt = pc_out_r;
      pc_valid_nxt = 1'b0;
      sfr_rdata_nxt = sfr_rdata_r;
      wr_en = 1'b0;
      wr_addr = sp_w;
      wr_byte = push_data;
      case (st_r)
         esp_pkg::ESP_IDLE: begin
            if (push_req || pc_push_req) begin
               np = inc_ptr(sp_w, base_w);
               wr_en = 1'b1;
               wr_addr = np;
               wr_byte = pc_push_req ? pc_in[7:0] : push_data;
               pch_nxt = pc_in[15:8];
               is_push_nxt = 1'b1;
               upd = 1'b1;
               if (pc_push_req) begin
                  st_nxt = esp_pkg::ESP_SECOND;
               end
            end else if (pop_req || pc_pop_req) begin
               pop_data_nxt = ram[sp_w];
               pop_valid_nxt = pop_req;
               pch_nxt = ram[sp_w];
               np = esp_pkg::esp_addr_t'(sp_w - 11'h001);
               is_push_nxt = 1'b0;
               upd = 1'b1;
               if (pc_pop_req) begin
                  st_nxt = esp_pkg::ESP_SECOND;
               end
            end else if (sfr_wr && sfr_addr == `ESP_ADDR_SP_LOW) begin
               np = {sp_w[10:8], sfr_wdata};
            end else if (sfr_wr && sfr_addr == `ESP_ADDR_SP_HIGH) begin
               hv = sfr_wdata;
               np = {sfr_wdata[`ESP_SPH_PTR_HI:0], spl_r};
               nb = base_of(sfr_wdata);
            end
            // pointer writes below the base are refused when guarded
            if (sfr_wr && !push_req && !pc_push_req && !pop_req && !pc_pop_req &&
                (sfr_addr == `ESP_ADDR_SP_LOW || sfr_addr == `ESP_ADDR_SP_HIGH)) begin
               if (guard_on && np < nb) begin
                  floor_v = 1'b1;
               end else begin
                  sph_nxt = {1'b1, sph_r[`ESP_SPH_FLOOR_BIT] & hv[`ESP_SPH_FLOOR_BIT],
                             hv[`ESP_SPH_BASE_HI:`ESP_SPH_BASE_LO], np[10:8]};
                  spl_nxt = np[7:0];
                  upd = 1'b1;
               end
            end else begin
               sph_nxt[`ESP_SPH_PTR_HI:0] = np[10:8];
               spl_nxt = np[7:0];
            end
            if (sfr_wr && sfr_addr == `ESP_ADDR_GUARD) begin
               grd_nxt[7:1] = sfr_wdata[7:1];
               // clear only honoured below the waterline
               if (!sfr_wdata[`ESP_GRD_WFLAG_BIT] && sp_w < wline_w) begin
                  grd_nxt[`ESP_GRD_WFLAG_BIT] = 1'b0;
               end
            end
            if (sfr_rd) begin
               sfr_rdata_nxt = (sfr_addr == `ESP_ADDR_SP_LOW) ? spl_r :
                               (sfr_addr == `ESP_ADDR_SP_HIGH) ? sph_r :
                               (sfr_addr == `ESP_ADDR_GUARD) ? grd_r : 8'h00;
            end
         end
         esp_pkg::ESP_SECOND: begin
            is_push_nxt = is_push_r;
            if (is_push_r) begin
               np = inc_ptr(sp_w, base_w);
               wr_en = 1'b1;
               wr_addr = np;
               wr_byte = pch_r;
            end else begin
               pc_out_nxt = {pch_r, ram[sp_w]};
               pc_valid_nxt = 1'b1;
               np = esp_pkg::esp_addr_t'(sp_w - 11'h001);
            end
            sph_nxt[`ESP_SPH_PTR_HI:0] = np[10:8];
            spl_nxt = np[7:0];
            upd = 1'b1;
            st_nxt = esp_pkg::ESP_DONE;
         end
         esp_pkg::ESP_DONE: begin
            st_nxt = esp_pkg::ESP_IDLE;
         end
         default: begin
            st_nxt = esp_pkg::ESP_IDLE;
         end
      endcase
      // waterline checked against the pointer that is being stored;
      // gating on upd keeps a parked pointer from pulsing every cycle
      wl_v = wl_live && upd && ({sph_nxt[`ESP_SPH_PTR_HI:0], spl_nxt} > wline_w);
      if (wl_v) begin
         grd_nxt[`ESP_GRD_WFLAG_BIT] = 1'b1;
      end
      if (floor_v) begin
         sph_nxt[`ESP_SPH_FLOOR_BIT] = 1'b1;
      end
      // global enable is not consulted; the vector is high priority
      irq_nxt = (wl_v || floor_v) && guard_on && !grd_r[`ESP_GRD_RSP_BIT];
      rst_nxt = (wl_v || floor_v) && guard_on && grd_r[`ESP_GRD_RSP_BIT];
   end

   // stack ram write port
   // single write port, combinational read in the sequencer; this keeps
   // pops to one cycle at the cost of a read path through the ram array
   // and the pointer mux, which is the longest path of the block
   always_ff @(posedge clk) begin
      if (wr_en) begin
         ram[wr_addr] <= wr_byte;
      end
   end

   // state registers; the cause flags ride through a block reset; of the resets only
   // the pin reset clears them, so software can still read why it restarted.
   // one process owns every bit of each register, so no variable has two
   // writers; the pin reset is folded in as a mask on the flag bits
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         spl_r <= `ESP_SPL_RESET;
         sph_r <= (`ESP_SPH_RESET & 8'hbf) | {1'b0, sph_r[`ESP_SPH_FLOOR_BIT] & pin_rst_n, 6'h00};
         grd_r <= (`ESP_GUARD_RESET & 8'hfe) | {7'h00, grd_r[`ESP_GRD_WFLAG_BIT] & pin_rst_n};
         st_r <= esp_pkg::ESP_IDLE;
         pch_r <= 8'h00;
         is_push_r <= 1'b0;
         pop_data_r <= 8'h00;
         pop_valid_r <= 1'b0;
         pc_out_r <= 16'h0000;
         pc_valid_r <= 1'b0;
         sfr_rdata_r <= 8'h00;
         irq_r <= 1'b0;
         rst_r <= 1'b0;
      end else begin
         spl_r <= spl_nxt;
         // pin reset alone clears the flags while the block keeps running
         sph_r <= {sph_nxt[7], sph_nxt[`ESP_SPH_FLOOR_BIT] & pin_rst_n, sph_nxt[5:0]};
         grd_r <= {grd_nxt[7:1], grd_nxt[`ESP_GRD_WFLAG_BIT] & pin_rst_n};
         st_r <= st_nxt;
         pch_r <= pch_nxt;
         is_push_r <= is_push_nxt;
         pop_data_r <= pop_data_nxt;
         pop_valid_r <= pop_valid_nxt;
         pc_out_r <= pc_out_nxt;
         pc_valid_r <= pc_valid_nxt;
         sfr_rdata_r <= sfr_rdata_nxt;
         irq_r <= irq_nxt;
         rst_r <= rst_nxt;
      end
   end

   // output drive
   // all data outputs come straight from flip-flops so the core sees
   // clean values a full cycle after the request; only busy is decoded
   // from the state, which lets the core stall in the same cycle.
   // the violation pulses are not stretched: the core is expected to
   // latch them, and the cause flags stay readable afterwards anyway.
   // a limitation worth knowing: a push and a pc save raised together
   // are treated as a pc save, the core should never issue both.
   // another one: a read and a write in one cycle read the old value,
   // since the read data is taken from the registers before the update.
   // the ram has no reset; popping an unwritten slot returns unknown
   // data, which is the same as on a real power-up stack.
   assign sfr_rdata = sfr_rdata_r;
   assign pop_data = pop_data_r;
   assign pop_valid = pop_valid_r;
   assign pc_out = pc_out_r;
   assign pc_valid = pc_valid_r;
   assign busy = (st_r != esp_pkg::ESP_IDLE);
   assign viol_irq_req = irq_r;
   assign viol_rst_req = rst_r;
endmodule

// [shared/esp_defs.svh]
// constants for the extended stack pointer guard
`ifndef ESP_DEFS_SVH
`define ESP_DEFS_SVH
`define ESP_ADDR_SP_LOW 8'h81
`define ESP_ADDR_SP_HIGH 8'hb7
`define ESP_ADDR_GUARD 8'hbf
`define ESP_SPH_RESET 8'h89
`define ESP_SPL_RESET 8'h00
`define ESP_GUARD_RESET 8'h00
`define ESP_SPH_RSVD_BIT 7
`define ESP_SPH_FLOOR_BIT 6
`define ESP_SPH_BASE_HI 5
`define ESP_SPH_BASE_LO 3
`define ESP_SPH_PTR_HI 2
`define ESP_GRD_LVL_HI 7
`define ESP_GRD_LVL_LO 3
`define ESP_GRD_RSP_BIT 2
`define ESP_GRD_EN_BIT 1
`define ESP_GRD_WFLAG_BIT 0
`define ESP_RAM_TOP 11'h7ff
`define ESP_RAM_WORDS 2048
`endif

// [shared/esp_pkg.sv]
// types for the extended stack pointer guard
package esp_pkg;
   typedef logic [10:0] esp_addr_t;
   typedef enum logic [2:0] {
      ESP_IDLE = 3'b001,
      ESP_SECOND = 3'b010,
      ESP_DONE = 3'b100
   } esp_state_t;
endpackage
